//--- common/fsc_pkg.sv
// Purpose: Constants and types for the fan supervision and drive block.
// Assumes: 25 MHz pclk; APB byte address = register index * 4.
// Notes:   Operation list below, one line per behaviour.
// Operation
// - Tach-powered select 1: no forced drive, duty only, no correction, continuous tach.
// - Tach-powered 0 in speed regulation: duty below 30% raised to 30%.
// - Tach-powered 0 in other modes with tach on: duty below 7% gives 0%, no period updates.
// - Period above minimum-speed limit sets slow flag; never during spin-up.
// - Slow flag clears on status read, resets next measurement, set after spin-up.
// - Period below maximum-speed limit sets overspeed flag; re-arms only after slowing.
// - Slow or overspeed flag with its enable pulls SMBALERT low.
// - Slow measurement with spin-up enabled starts a timed spin-up.
// - Five spin-ups without recovery declare failure; spin-up keeps repeating.
// - Measure every 0.25 s or 1 s, also after failure and right after spin-up.
// - Failure pin open-drain, released when disabled or speed recovers.
// - Overheat pin low above either limit until 5 degrees below it.
// - Limit crossing sets overheat flag; SMBALERT only when its enable is set.
// - Status read clears overheat flags, not the pin; re-arm 5 degrees below.
// - Own overheat drive with full-speed enable gives 100% duty.
// - Externally pulled overheat pin sets input flag and forces 100% duty.
// - Spin-up ramps 33.3% to 100% over first third, holds, ends at 33.3%.
// - Spin-up time select decodes 0.2 s to 8 s, default 2 s.
// - Spin-up disable bit suppresses spin-up; zero after reset.
// - Mode select 00 applies host duty value right after the write.
// - Software duty with tach on and tach-powered 0: below 7% gives 0%.
// - Mode select 01 speed regulation, 10 remote auto (default), 11 fastest auto.
// - Duty value maps linearly, 0x00 is 0% and 0xFF is 100%.
`default_nettype none
package fsc_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
  localparam int unsigned MEAS_FAST_MS = 250;
  localparam int unsigned MEAS_SLOW_MS = 1000;
  localparam int unsigned RAMP_STEPS   = 510;  // 170 steps span one third of the time
  // --------------------------------------------------------------
  // Register indices
  // --------------------------------------------------------------
  localparam logic [7:0] IDX_CFG1    = 8'h00;
  localparam logic [7:0] IDX_CFG2    = 8'h01;
  localparam logic [7:0] IDX_STAT1   = 8'h02;
  localparam logic [7:0] IDX_STAT2   = 8'h03;
  localparam logic [7:0] IDX_CFG4    = 8'h04;
  localparam logic [7:0] IDX_LO_LIM  = 8'h10;
  localparam logic [7:0] IDX_HI_LIM  = 8'h11;
  localparam logic [7:0] IDX_RLIM    = 8'h12;
  localparam logic [7:0] IDX_LLIM    = 8'h13;
  localparam logic [7:0] IDX_FANCHAR = 8'h20;
  localparam logic [7:0] IDX_DUTY    = 8'h22;
  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int CFG1_SPEED_RANGE_IRQ_ENABLE    = 2;
  localparam int CFG1_OHIE     = 3;
  localparam int CFG1_FAULT_EN = 4;
  localparam int CFG1_MODE_LSB = 5;
  localparam int CFG1_OHFS     = 7;
  localparam int CFG2_TPWR     = 1;
  localparam int CFG2_TACH_EN  = 2;
  localparam int CFG4_FAST     = 5;
  localparam int FCH_STIME_LSB = 0;
  localparam int FCH_SPIN_DIS  = 5;
  localparam int ST1_SLOW      = 0;
  localparam int ST1_OVS       = 1;
  localparam int ST1_RTH       = 2;
  localparam int ST2_LTH       = 0;
  localparam int ST2_EXT       = 1;
  localparam int ST2_FAIL      = 2;
  // --------------------------------------------------------------
  // Reset values and duty levels
  // --------------------------------------------------------------
  localparam logic [7:0]  CFG1_RST    = 8'h40;
  localparam logic [7:0]  CFG2_RST    = 8'h04;
  localparam logic [7:0]  CFG4_RST    = 8'h00;
  localparam logic [7:0]  FCH_RST     = 8'h05;
  localparam logic [7:0]  DUTY_RST    = 8'h00;
  localparam logic [15:0] LO_LIM_RST  = 16'hFFFF;
  localparam logic [15:0] HI_LIM_RST  = 16'h0000;
  localparam logic [7:0]  OHLIM_RST   = 8'h55;
  localparam logic [7:0]  DUTY_FULL   = 8'hFF;
  localparam logic [7:0]  DUTY_SPIN   = 8'h55;
  localparam logic [7:0]  DUTY_REG_MIN = 8'h4D;
  localparam logic [7:0]  DUTY_OFF_MIN = 8'h12;
  localparam logic [7:0]  DUTY_ZERO   = 8'h00;
  localparam logic [8:0]  OH_HYST     = 9'h005;
  localparam logic [2:0]  SPIN_RETRY  = 3'h5;

  typedef enum logic [1:0] {
    MODE_SW_DUTY = 2'b00,
    MODE_SPD_REG = 2'b01,
    MODE_AUTO_RM = 2'b10,
    MODE_AUTO_MX = 2'b11
  } fsc_mode_type;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_SPIN   = 2'b01,
    ST_POST   = 2'b11
  } fsc_state_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] period;
  } fsc_tach_type;

  typedef struct packed {
    logic [7:0] remote;
    logic [7:0] local_t;
  } fsc_temp_type;

  function automatic int unsigned spin_ms(input logic [2:0] sel);
    int unsigned ms;
    unique case (sel)
      3'h0: ms = 200;
      3'h1: ms = 400;
      3'h2: ms = 600;
      3'h3: ms = 800;
      3'h4: ms = 1000;
      3'h5: ms = 2000;
      3'h6: ms = 4000;
      3'h7: ms = 8000;
    endcase
    return ms;
  endfunction
endpackage
`default_nettype wire

//--- hdl/fsc_top.sv
// Purpose: Fan supervision, spin-up, overheat pin and duty selection with APB registers.
// Assumes: Tach period and temperatures come from logic on pclk.
// Notes:   Open-drain pins drive low whenever their enable is high.
`timescale 1ns/10ps
`default_nettype none
module fsc_top #(
  parameter int unsigned CYC_PER_MS = fsc_pkg::CYC_PER_MS
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire fsc_pkg::fsc_tach_type tach_in,
  input  wire fsc_pkg::fsc_temp_type temp_in,
  input  wire logic [7:0]            calc_duty,
  output var  logic                  meas_req,
  output var  logic                  tach_update_en,
  output var  logic                  tach_continuous,
  output var  logic                  pwm_force_on,
  output var  logic                  correction_en,
  output var  logic [7:0]            duty_out,
  output var  logic                  spin_active,
  input  wire logic                  overheat_pin_i,
  output var  logic                  overheat_pin_o,
  output var  logic                  overheat_pin_oe,
  output var  logic                  fault_o,
  output var  logic                  fault_oe,
  output var  logic                  alert_o,
  output var  logic                  alert_oe
);
  import fsc_pkg::*;

  typedef struct packed {
    logic [7:0]       cfg1;
    logic [7:0]       cfg2;
    logic [7:0]       cfg4;
    logic [7:0]       fanchar;
    logic [7:0]       duty_value;
    logic [15:0]      lo_lim;
    logic [15:0]      hi_lim;
    logic [1:0][7:0]  oh_lim;

    logic             slow;
    logic             ovs;
    logic             ovs_armed;
    logic [1:0]       oh_hold;
    logic [1:0]       oh_flag;
    logic [1:0]       oh_armed;
    logic             ext_flag;
    logic [1:0]       drv_hist;
    logic [1:0]       sync;

    logic             fail;
    logic [2:0]       attempts;
    fsc_state_type    st;

    logic [31:0]      meas_cnt;
    logic [31:0]      spin_cnt;
    logic [31:0]      step_cnt;
    logic [7:0]       ramp_duty;
    logic [7:0]       duty;
    logic             meas_req;
    logic             tach_upd;
    logic [31:0]      prdata;
  } fsc_regs_type;

  localparam fsc_regs_type REGS_RST = '{
    cfg1: CFG1_RST, cfg2: CFG2_RST, cfg4: CFG4_RST, fanchar: FCH_RST,
    duty_value: DUTY_RST, lo_lim: LO_LIM_RST, hi_lim: HI_LIM_RST,
    oh_lim: {OHLIM_RST, OHLIM_RST}, slow: 1'b0, ovs: 1'b0, ovs_armed: 1'b1,
    oh_hold: 2'b00, oh_flag: 2'b00, oh_armed: 2'b11, ext_flag: 1'b0,
    drv_hist: 2'b00, sync: 2'b11, fail: 1'b0, attempts: 3'h0, st: ST_NORMAL,
    meas_cnt: 32'h0000_0000, spin_cnt: 32'h0000_0000, step_cnt: 32'h0000_0000,
    ramp_duty: DUTY_SPIN, duty: DUTY_ZERO, meas_req: 1'b0, tach_upd: 1'b1,
    prdata: 32'h0000_0000};

  fsc_regs_type s_r;
  fsc_regs_type s_nxt;

  // --------------------------------------------------------------
  // Decoded controls
  // --------------------------------------------------------------
  logic [7:0]   idx;
  logic         mapped;
  logic         wr_acc;
  logic         rd_acc;

  fsc_mode_type mode;
  logic         tpwr;
  logic         tach_en;
  logic         ext_low;

  logic [31:0]  spin_cyc;
  logic [31:0]  step_cyc;
  logic [31:0]  meas_cyc;

  assign idx     = paddr[9:2];
  assign mapped  = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                   (idx == IDX_CFG1 || idx == IDX_CFG2 || idx == IDX_STAT1 ||
                    idx == IDX_STAT2 || idx == IDX_CFG4 || idx == IDX_LO_LIM ||
                    idx == IDX_HI_LIM || idx == IDX_RLIM || idx == IDX_LLIM ||
                    idx == IDX_FANCHAR || idx == IDX_DUTY);
  assign wr_acc  = psel && penable && pwrite && mapped;
  assign rd_acc  = psel && penable && !pwrite && mapped;

  assign mode    = fsc_mode_type'(s_r.cfg1[CFG1_MODE_LSB +: 2]);
  assign tpwr    = s_r.cfg2[CFG2_TPWR];
  assign tach_en = s_r.cfg2[CFG2_TACH_EN];
  // Own drive echoes back through the synchroniser for two cycles
  assign ext_low = !s_r.sync[1] && (s_r.oh_hold == 2'b00) && (s_r.drv_hist == 2'b00);

  // Long timers scale with CYC_PER_MS
  assign spin_cyc = 32'(spin_ms(s_r.fanchar[FCH_STIME_LSB +: 3]) * CYC_PER_MS);
  assign step_cyc = (spin_cyc / RAMP_STEPS == 0) ? 32'h0000_0001 : spin_cyc / RAMP_STEPS;
  assign meas_cyc = s_r.cfg4[CFG4_FAST] ? 32'(MEAS_FAST_MS * CYC_PER_MS)
                                        : 32'(MEAS_SLOW_MS * CYC_PER_MS);

  function automatic logic [31:0] read_mux(input fsc_regs_type r, input logic [7:0] i);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (i)
      IDX_CFG1:    d[7:0] = r.cfg1;
      IDX_CFG2:    d[7:0] = r.cfg2;
      IDX_STAT1:   d[2:0] = {r.oh_flag[0], r.ovs, r.slow};
      IDX_STAT2:   d[2:0] = {r.fail, r.ext_flag, r.oh_flag[1]};
      IDX_CFG4:    d[7:0] = r.cfg4;
      IDX_LO_LIM:  d[15:0] = r.lo_lim;
      IDX_HI_LIM:  d[15:0] = r.hi_lim;
      IDX_RLIM:    d[7:0] = r.oh_lim[0];
      IDX_LLIM:    d[7:0] = r.oh_lim[1];
      IDX_FANCHAR: d[7:0] = r.fanchar;
      IDX_DUTY:    d[7:0] = r.duty_value;
      default:     d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    logic [1:0]  clr_oh;
    logic [1:0]  exceed;
    logic [1:0]  release_t;
    logic [7:0]  temp;
    logic        use_meas;
    logic        slow_now;
    logic        fast_now;
    logic [7:0]  base;
    logic        upd;
    logic        full_speed;

    clr_oh     = 2'b00;
    exceed     = 2'b00;
    release_t  = 2'b00;
    temp       = 8'h00;
    use_meas   = 1'b0;
    slow_now   = 1'b0;
    fast_now   = 1'b0;
    base       = DUTY_ZERO;
    upd        = 1'b1;
    full_speed = 1'b0;

    s_nxt          = s_r;
    s_nxt.meas_req = 1'b0;
    s_nxt.sync     = {s_r.sync[0], overheat_pin_i};
    s_nxt.drv_hist = {s_r.drv_hist[0], |s_r.oh_hold};


    // Register writes
    if (wr_acc) begin
      unique case (idx)
        IDX_CFG1:    s_nxt.cfg1 = pwdata[7:0];
        IDX_CFG2:    s_nxt.cfg2 = pwdata[7:0];
        IDX_CFG4:    s_nxt.cfg4 = pwdata[7:0];
        IDX_LO_LIM:  s_nxt.lo_lim = pwdata[15:0];
        IDX_HI_LIM:  s_nxt.hi_lim = pwdata[15:0];
        IDX_RLIM:    s_nxt.oh_lim[0] = pwdata[7:0];
        IDX_LLIM:    s_nxt.oh_lim[1] = pwdata[7:0];
        IDX_FANCHAR: s_nxt.fanchar = pwdata[7:0];
        IDX_DUTY:    s_nxt.duty_value = pwdata[7:0];
        default:     s_nxt.cfg1 = s_r.cfg1;
      endcase
    end

    // Read data is fetched in setup so it stands through the access cycle
    if (psel && !penable) begin
      s_nxt.prdata = read_mux(s_r, idx);
    end

    // Read clears first; any set below wins
    if (rd_acc && idx == IDX_STAT1) begin
      s_nxt.slow = 1'b0;
      s_nxt.ovs  = 1'b0;
      clr_oh[0]  = 1'b1;
    end

    if (rd_acc && idx == IDX_STAT2) begin
      s_nxt.ext_flag = 1'b0;
      clr_oh[1]      = 1'b1;
    end

    // --------------------------------------------------------------
    // Overheat channels: 0 remote, 1 local
    // --------------------------------------------------------------
    for (int ch = 0; ch < 2; ch++) begin
      temp = (ch == 0) ? temp_in.remote : temp_in.local_t;
      exceed[ch]    = temp > s_r.oh_lim[ch];
      release_t[ch] = ({1'b0, temp} + OH_HYST) <= {1'b0, s_r.oh_lim[ch]};
      if (release_t[ch]) begin
        s_nxt.oh_hold[ch]  = 1'b0;
        s_nxt.oh_armed[ch] = 1'b1;
      end
      if (exceed[ch]) begin
        s_nxt.oh_hold[ch] = 1'b1;
      end
      if (clr_oh[ch]) begin
        s_nxt.oh_flag[ch] = 1'b0;
      end
      // Re-arm only through hysteresis
      if (exceed[ch] && s_r.oh_armed[ch]) begin
        s_nxt.oh_flag[ch]  = 1'b1;
        s_nxt.oh_armed[ch] = 1'b0;
      end
    end

    if (ext_low) begin
      s_nxt.ext_flag = 1'b1;
    end

    // --------------------------------------------------------------
    // Measurement timing and speed checks
    // --------------------------------------------------------------
    if (s_r.st != ST_SPIN && tach_en) begin
      if (s_r.meas_cnt == 32'h0000_0000) begin
        s_nxt.meas_req = 1'b1;
        s_nxt.meas_cnt = meas_cyc - 32'h0000_0001;
      end else begin
        s_nxt.meas_cnt = s_r.meas_cnt - 32'h0000_0001;
      end
    end

    // Results during spin-up are dropped
    use_meas = tach_in.valid && s_r.tach_upd && tach_en && s_r.st != ST_SPIN;
    slow_now = tach_in.period > s_r.lo_lim;
    fast_now = tach_in.period < s_r.hi_lim;
    if (use_meas) begin
      if (slow_now) begin
        s_nxt.slow = 1'b1;
      end
      if (!fast_now) begin
        s_nxt.ovs_armed = 1'b1;
      end else if (s_r.ovs_armed) begin
        s_nxt.ovs       = 1'b1;
        s_nxt.ovs_armed = 1'b0;
      end
      if (!slow_now) begin
        s_nxt.attempts = 3'h0;
        s_nxt.fail     = 1'b0;
      end

      if (s_r.st == ST_POST) begin
        s_nxt.st = ST_NORMAL;
      end

      if (slow_now && !s_r.fanchar[FCH_SPIN_DIS]) begin
        s_nxt.st        = ST_SPIN;
        s_nxt.spin_cnt  = spin_cyc - 32'h0000_0001;
        s_nxt.step_cnt  = step_cyc - 32'h0000_0001;
        s_nxt.ramp_duty = DUTY_SPIN;
        if (s_r.attempts == SPIN_RETRY) begin
          s_nxt.fail = 1'b1;
        end else begin
          s_nxt.attempts = s_r.attempts + 3'h1;
        end
      end
    end

    // --------------------------------------------------------------
    // Spin-up sequence
    // --------------------------------------------------------------
    if (s_r.st == ST_SPIN) begin
      if (s_r.step_cnt == 32'h0000_0000) begin
        s_nxt.step_cnt = step_cyc - 32'h0000_0001;
        if (s_r.ramp_duty != DUTY_FULL) begin
          s_nxt.ramp_duty = s_r.ramp_duty + 8'h01;
        end
      end else begin
        s_nxt.step_cnt = s_r.step_cnt - 32'h0000_0001;
      end

      if (s_r.spin_cnt == 32'h0000_0000) begin
        s_nxt.st       = ST_POST;
        s_nxt.slow     = 1'b1;
        s_nxt.meas_req = 1'b1;
        s_nxt.meas_cnt = meas_cyc - 32'h0000_0001;
      end else begin
        s_nxt.spin_cnt = s_r.spin_cnt - 32'h0000_0001;
      end
    end

    // --------------------------------------------------------------
    // Duty selection
    // --------------------------------------------------------------
    base = (mode == MODE_SW_DUTY) ? s_r.duty_value : calc_duty;
    if (!tpwr) begin
      if (mode == MODE_SPD_REG) begin
        if (base < DUTY_REG_MIN) begin
          base = DUTY_REG_MIN;
        end
      end else if (tach_en && base < DUTY_OFF_MIN) begin
        base = DUTY_ZERO;
        upd  = 1'b0;
      end
    end

    s_nxt.tach_upd = upd;
    // Overheat outranks the spin-up ramp
    full_speed = ((|s_r.oh_hold) && s_r.cfg1[CFG1_OHFS]) || ext_low;
    if (full_speed) begin
      s_nxt.duty = DUTY_FULL;
    end else if (s_nxt.st == ST_SPIN) begin
      s_nxt.duty = s_nxt.ramp_duty;
    end else if (s_nxt.st == ST_POST) begin
      s_nxt.duty = DUTY_SPIN;
    end else begin
      s_nxt.duty = base;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= REGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign prdata          = s_r.prdata;
  // No wait states
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !mapped;

  assign meas_req        = s_r.meas_req;
  assign tach_update_en  = s_r.tach_upd;
  assign tach_continuous = tpwr;
  assign pwm_force_on    = !tpwr;
  assign correction_en   = !tpwr;

  assign duty_out        = s_r.duty;
  assign spin_active     = (s_r.st == ST_SPIN);

  assign overheat_pin_o  = 1'b0;
  assign overheat_pin_oe = |s_r.oh_hold;

  assign fault_o         = 1'b0;
  assign fault_oe        = s_r.fail && s_r.cfg1[CFG1_FAULT_EN];

  assign alert_o         = 1'b0;
  assign alert_oe        = ((s_r.slow || s_r.ovs) && s_r.cfg1[CFG1_SPEED_RANGE_IRQ_ENABLE]) ||
                           ((|s_r.oh_flag) && s_r.cfg1[CFG1_OHIE]);
endmodule
`default_nettype wire

//--- tb/fsc_top_monitor.sv
// Purpose: Port checker for fsc_top.
// Assumes: Mode and enables mirrored from APB writes.
// Notes:   Bound to fsc_top at the foot.
`timescale 1ns/10ps
`default_nettype none
module fsc_top_monitor import fsc_pkg::*; #(
  parameter int unsigned CYC_PER_MS = 10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        meas_req,
  input wire logic        tach_continuous,
  input wire logic        pwm_force_on,
  input wire logic        correction_en,
  input wire logic [7:0]  duty_out,
  input wire logic        spin_active,
  input wire logic        overheat_pin_i,
  input wire logic        overheat_pin_oe,
  input wire logic        fault_oe
);
  localparam int unsigned GAP_MAX = MEAS_SLOW_MS * CYC_PER_MS + 4;
  logic [1:0]  mode_r;
  logic        ohfs_r;
  logic        flt_en_r;
  logic [7:0]  dval_r;
  logic [31:0] gap_r;
  wire logic   wr_cfg = psel && penable && pwrite && paddr == {2'b00, IDX_CFG1, 2'b00};
  wire logic   wr_dty = psel && penable && pwrite && paddr == {2'b00, IDX_DUTY, 2'b00};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r   <= 2'b10;
      ohfs_r   <= 1'b0;
      flt_en_r <= 1'b0;
      dval_r   <= 8'h00;
      gap_r    <= 32'h0000_0000;
    end else begin
      mode_r   <= wr_cfg ? pwdata[6:5] : mode_r;
      ohfs_r   <= wr_cfg ? pwdata[7] : ohfs_r;
      flt_en_r <= wr_cfg ? pwdata[4] : flt_en_r;
      dval_r   <= wr_dty ? pwdata[7:0] : dval_r;
      gap_r    <= (meas_req || spin_active) ? 32'h0000_0000 : gap_r + 32'h0000_0001;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ext_low;
    (!overheat_pin_i && !overheat_pin_oe && !spin_active) [*6];
  endsequence
  sequence s_duty_wr;
    wr_dty && mode_r == MODE_SW_DUTY && pwdata[7:0] >= DUTY_OFF_MIN && !spin_active
      && overheat_pin_i && !overheat_pin_oe;
  endsequence
  property p_tpwr; tach_continuous |-> !pwm_force_on && !correction_en; endproperty
  property p_spin_start; $rose(spin_active) |-> duty_out == DUTY_SPIN; endproperty
  property p_spin_floor; spin_active |-> duty_out >= DUTY_SPIN; endproperty
  property p_meas_pulse; meas_req |=> !meas_req; endproperty
  property p_meas_gap; gap_r <= GAP_MAX; endproperty
  property p_ext_full; s_ext_low |-> duty_out == DUTY_FULL; endproperty
  property p_oh_full;
    (overheat_pin_oe && ohfs_r && !spin_active) [*3] |-> duty_out == DUTY_FULL;
  endproperty
  property p_sw_duty; s_duty_wr |-> ##[1:2] duty_out == dval_r; endproperty
  property p_fault_en; fault_oe |-> flt_en_r || $past(flt_en_r); endproperty
  a_tpwr: assert property (p_tpwr) else $error("tach powered drive wrong");
  a_spin_start: assert property (p_spin_start) else $error("spin start duty");
  a_spin_floor: assert property (p_spin_floor) else $error("spin duty low");
  a_meas_pulse: assert property (p_meas_pulse) else $error("meas pulse long");
  a_meas_gap: assert property (p_meas_gap) else $error("meas gap long");
  a_ext_full: assert property (p_ext_full) else $error("ext hot not full");
  a_oh_full: assert property (p_oh_full) else $error("overheat not full");
  a_sw_duty: assert property (p_sw_duty) else $error("host duty not applied");
  a_fault_en: assert property (p_fault_en) else $error("fault pin disabled");
endmodule
bind fsc_top fsc_top_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .meas_req, .tach_continuous, .pwm_force_on,
  .correction_en, .duty_out, .spin_active, .overheat_pin_i, .overheat_pin_oe, .fault_oe);
`default_nettype wire

//--- tb/fsc_fan_model.sv
// Purpose: Fan tach answer and external overheat puller.
// Assumes: Tach result arrives five cycles after each request.
// Notes:   Period lines show the inverse between results.
`timescale 1ns/10ps
`default_nettype none
module fsc_fan_model import fsc_pkg::*; (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         meas_req,
  input  wire logic [15:0]  period,
  input  wire logic         ext_hot,
  input  wire logic         oh_oe,
  output var  fsc_tach_type tach,
  output var  logic         oh_pin
);
  logic [2:0] dly_r;
  // Pulled-up wire: low if either side pulls
  assign oh_pin = !(oh_oe || ext_hot);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_r <= 3'h0;
      tach  <= '0;
    end else begin
      dly_r       <= meas_req ? 3'h4 : (dly_r != 3'h0 ? dly_r - 3'h1 : 3'h0);
      tach.valid  <= dly_r == 3'h1;
      tach.period <= (dly_r == 3'h1) ? period : ~period;
    end
  end
endmodule
`default_nettype wire

//--- tb/fsc_top_tb_top.sv
// Purpose: Self-checking bench for fsc_top.
// Assumes: CYC_PER_MS cut to 10, so spin-up at 0.2 s is 2000 cycles.
// Notes:   Samples right after an edge see settled pre-edge values.
`timescale 1ns/10ps
`default_nettype none
module fsc_top_tb_top;
  import fsc_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic         meas_req, tach_update_en, tach_continuous, pwm_force_on, correction_en;
  logic         spin_active, overheat_pin_i, overheat_pin_oe, fault_oe, alert_oe, ext_hot;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, q;
  logic [15:0]  period;
  logic [7:0]   calc_duty, duty_out;
  fsc_tach_type tach_in;
  fsc_temp_type temp_in;
  int           fails, checks;
  fsc_top #(.CYC_PER_MS(10)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tach_in, .temp_in, .calc_duty, .meas_req,
    .tach_update_en, .tach_continuous, .pwm_force_on, .correction_en, .duty_out,
    .spin_active, .overheat_pin_i, .overheat_pin_o(), .overheat_pin_oe, .fault_o(),
    .fault_oe, .alert_o(), .alert_oe);
  fsc_fan_model u_fan (.pclk, .presetn, .meas_req, .period, .ext_hot,
    .oh_oe(overheat_pin_oe), .tach(tach_in), .oh_pin(overheat_pin_i));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0000_0000);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wait_on(ref logic s, input logic lvl);
    int n;
    n = 0;
    while (s !== lvl && n < 30000) begin
      @(posedge pclk);
      n++;
    end
    chk(s, lvl);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(IDX_CFG1);
    chk(q, 32'h0000_0040);
    rd(IDX_FANCHAR);
    chk(q, 32'h0000_0005);
    rd(8'h3F);
    chk({q[31:1], err}, 32'h0000_0001);
  endtask
  task automatic t_modes;
    calc_duty <= 8'h10;
    wr(IDX_CFG1, 32'h0000_0020);
    cyc(3);
    chk(duty_out, DUTY_REG_MIN);
    calc_duty <= 8'h40;
    wr(IDX_CFG1, 32'h0000_0060);
    cyc(3);
    chk(duty_out, 8'h40);
    calc_duty <= 8'h11;
    cyc(3);
    chk({tach_update_en, duty_out}, 9'h000);
    wr(IDX_CFG1, 32'h0000_0000);
    wr(IDX_DUTY, 32'h0000_0080);
    cyc(2);
    chk(duty_out, 8'h80);
    wr(IDX_DUTY, 32'h0000_0011);
    cyc(2);
    chk(duty_out, DUTY_ZERO);
    wr(IDX_CFG2, 32'h0000_0006);
    cyc(2);
    chk({tach_continuous, pwm_force_on, correction_en, duty_out}, 11'h411);
    wr(IDX_CFG2, 32'h0000_0004);
    wr(IDX_DUTY, 32'h0000_00FF);
  endtask
  task automatic t_spin;
    wr(IDX_CFG1, 32'h0000_0010);
    wr(IDX_FANCHAR, 32'h0000_0000);
    wr(IDX_CFG4, 32'h0000_0020);
    period <= 16'h2000;
    wr(IDX_LO_LIM, 32'h0000_1000);
    for (int i = 0; i < 6; i++) begin
      wait_on(spin_active, 1'b1);
      chk(duty_out, DUTY_SPIN);
      wait_on(spin_active, 1'b0);
    end
    chk(fault_oe, 1'b1);
    rd(IDX_STAT2);
    chk(q[2], 1'b1);
    rd(IDX_STAT1);
    chk(q[0], 1'b1);
    period <= 16'h0800;
    wait_on(fault_oe, 1'b0);
    wr(IDX_FANCHAR, 32'h0000_0020);
    period <= 16'h2000;
    cyc(2600);
    chk({spin_active, fault_oe}, 2'b00);
    period <= 16'h0800;
    rd(IDX_STAT1);
  endtask
  task automatic t_ovs;
    wr(IDX_CFG1, 32'h0000_0004);
    wr(IDX_HI_LIM, 32'h0000_0400);
    period <= 16'h0100;
    wait_on(alert_oe, 1'b1);
    rd(IDX_STAT1);
    chk(q[1:0], 2'b10);
    cyc(2700);
    rd(IDX_STAT1);
    chk({q[1:0], alert_oe}, 3'b000);
    period <= 16'h0800;
  endtask
  task automatic t_heat;
    wr(IDX_CFG1, 32'h0000_0088);
    wr(IDX_DUTY, 32'h0000_0080);
    temp_in <= '{remote: 8'h60, local_t: 8'h20};
    cyc(5);
    chk({overheat_pin_oe, alert_oe, duty_out}, {2'b11, DUTY_FULL});
    rd(IDX_STAT1);
    chk(q[2], 1'b1);
    cyc(3);
    chk({overheat_pin_oe, alert_oe}, 2'b10);
    temp_in <= '{remote: 8'h51, local_t: 8'h20};
    cyc(3);
    chk(overheat_pin_oe, 1'b1);
    temp_in <= '{remote: 8'h50, local_t: 8'h20};
    cyc(3);
    chk(overheat_pin_oe, 1'b0);
    ext_hot <= 1'b1;
    cyc(6);
    chk(duty_out, DUTY_FULL);
    rd(IDX_STAT2);
    chk(q[1], 1'b1);
    ext_hot <= 1'b0;
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, ext_hot} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    period = 16'h0800;
    calc_duty = 8'h00;
    temp_in = '{remote: 8'h20, local_t: 8'h20};
    cyc(3);
    presetn <= 1'b1;
    cyc(1);
    t_regs;
    t_modes;
    t_spin;
    t_ovs;
    t_heat;
    stop_test;
  end
  initial begin
    cyc(80000);
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
